// >>> core/pcs_pkg.sv
// package of constants and types for the primitive cell set
package pcs_pkg;
    // number of tri-state drivers and their channel order
    localparam int PCS_NUM_DRV = 4;
    localparam int PCS_DRV_BUF_HI = 0;
    localparam int PCS_DRV_BUF_LO = 1;
    localparam int PCS_DRV_INV_HI = 2;
    localparam int PCS_DRV_INV_LO = 3;
    // per channel: complement the data, and enable active low
    localparam logic [PCS_NUM_DRV-1:0] PCS_INV_MASK = 4'hc;
    localparam logic [PCS_NUM_DRV-1:0] PCS_LOW_MASK = 4'ha;
    // reset values
    localparam logic PCS_RST_TRUE = 1'h0;
    localparam logic PCS_RST_INV = 1'h1;
    localparam logic PCS_RST_DRV_DATA = 1'h0;
    localparam logic PCS_RST_DRV_OE_B = 1'h1;
    localparam logic PCS_RST_SEL = 1'h0;
    localparam logic PCS_RST_CLK_PREV = 1'h0;

    typedef struct packed {
        logic true_v;
        logic inv_v;
    } pcs_store_t;
endpackage

// >>> core/pcs_store.sv
// storage cell shared by the level latch and the edge register
`timescale 1ns/1ps
module pcs_store (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic data,
    input wire logic load,
    input wire logic clear,
    input wire logic set,
    input wire logic clash_true_value,
    input wire logic clash_inverted_value,
    output logic true_output,
    output logic inverted_output
);
    // =====================================================
    // state
    pcs_pkg::pcs_store_t store_ff;
    pcs_pkg::pcs_store_t nxt_store;

    // =====================================================
    // next state
    // clash first, then clear, then set, then the load condition
    always_comb begin
        nxt_store = store_ff;
        if (!rst_b) begin
            nxt_store.true_v = pcs_pkg::PCS_RST_TRUE;
            nxt_store.inv_v = pcs_pkg::PCS_RST_INV;
        end else if (clk_en) begin
            if (clear && set) begin
                nxt_store.true_v = clash_true_value;
                nxt_store.inv_v = clash_inverted_value;
            end else if (clear) begin
                nxt_store.true_v = 1'h0;
                nxt_store.inv_v = 1'h1;
            end else if (set) begin
                nxt_store.true_v = 1'h1;
                nxt_store.inv_v = 1'h0;
            end else if (load) begin
                nxt_store.true_v = data;
                nxt_store.inv_v = ~data;
            end else begin
                nxt_store = store_ff;
            end
        end
    end

    // =====================================================
    // state register
    always_ff @(posedge clock) begin
        store_ff <= nxt_store;
    end

    // =====================================================
    // outputs
    assign true_output = store_ff.true_v;
    assign inverted_output = store_ff.inv_v;
endmodule

// >>> core/pcs_top.sv
// primitive cell set: tri-state drivers, selector, level latch, edge register
`timescale 1ns/1ps
// Contract
// - buffer, high enable: pass input while enable high, else float.
// - buffer, low enable: pass input while enable low, else float.
// - inverter, high enable: drive complement while enable high, else float.
// - inverter, low enable: drive complement while enable low, else float.
// - selector picks bit by select; equal bits give that value always.
// - latch with clear and set both active takes the clash values first.
// - latch: clear, then set, then enable-transparent data, in that order.
// - register clear and set override the clock; both give clash values.
module pcs_top (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [pcs_pkg::PCS_NUM_DRV-1:0] drv_in,
    input wire logic [pcs_pkg::PCS_NUM_DRV-1:0] drv_enable,
    output logic [pcs_pkg::PCS_NUM_DRV-1:0] drv_out,
    output logic [pcs_pkg::PCS_NUM_DRV-1:0] drv_oe_b,
    input wire logic [1:0] sel_data,
    input wire logic sel_select,
    output logic sel_out,
    input wire logic lat_data,
    input wire logic lat_enable,
    input wire logic lat_clear,
    input wire logic lat_set,
    input wire logic lat_clash_true_value,
    input wire logic lat_clash_inverted_value,
    output logic lat_true_output,
    output logic lat_inverted_output,
    input wire logic reg_data,
    input wire logic reg_clock,
    input wire logic reg_clear,
    input wire logic reg_set,
    input wire logic reg_clash_true_value,
    input wire logic reg_clash_inverted_value,
    output logic reg_true_output,
    output logic reg_inverted_output
);

    // =====================================================
    // overview
    // drivers: drv_in and drv_enable per channel; the package masks give each
    //   channel its data sense and its enable sense; outputs follow one cycle later
    // selector: sel_data and sel_select give sel_out one cycle later
    // latch and register: a shared storage cell resolves clear, set and their
    //   clash before the load condition; outputs follow one cycle later
    // clk_en low freezes every flop unless rst_b is low; rst_b low loads the reset values at the
    //   next edge of clock
    // no pin is driven here: oe_b tells the pad when to float the pin
    localparam int NUM_DRV = pcs_pkg::PCS_NUM_DRV;

    // =====================================================
    // state
    typedef struct packed {
        logic [NUM_DRV-1:0] data;
        logic [NUM_DRV-1:0] oe_b;
    } pcs_drv_state_t;

    typedef struct packed {
        pcs_drv_state_t drv;
        logic sel;
        logic reg_clk_prev;
    } pcs_top_state_t;

    pcs_top_state_t state_ff;
    pcs_top_state_t nxt_state;

    // =====================================================
    // operating mode
    typedef enum {
        MODE_RESET,
        MODE_RUN,
        MODE_FROZEN
    } pcs_top_mode_t;

    pcs_top_mode_t mode;

    assign mode = !rst_b ? MODE_RESET : (clk_en ? MODE_RUN : MODE_FROZEN);

    // =====================================================
    // tri-state drivers
    // the value to drive is registered even while the pin floats, so the pin
    // shows fresh data on the first cycle that its enable is taken
    logic [NUM_DRV-1:0] drv_active;
    logic [NUM_DRV-1:0] drv_data_calc;
    logic [NUM_DRV-1:0] drv_oe_b_calc;

    for (genvar ch = 0; ch < NUM_DRV; ch++) begin : g_drv
        localparam logic INV = pcs_pkg::PCS_INV_MASK[ch];
        localparam logic LOW = pcs_pkg::PCS_LOW_MASK[ch];

        // enable taken in the sense of this channel
        if (LOW) begin : g_low
            assign drv_active[ch] = ~drv_enable[ch];
        end else begin : g_high
            assign drv_active[ch] = drv_enable[ch];
        end

        // value put on the pin while driving
        if (INV) begin : g_inv
            assign drv_data_calc[ch] = ~drv_in[ch];
        end else begin : g_pass
            assign drv_data_calc[ch] = drv_in[ch];
        end

        // pin driven while oe_b is low, floated otherwise
        assign drv_oe_b_calc[ch] = ~drv_active[ch];
    end

    // =====================================================
    // two-way selector
    // the consensus term holds the output high when both data bits are high,
    // whatever the select does
    logic sel_pick;
    logic sel_agree;
    logic sel_calc;

    assign sel_pick = sel_select ? sel_data[1] : sel_data[0];
    assign sel_agree = sel_data[0] & sel_data[1];
    assign sel_calc = sel_pick | sel_agree;

    // =====================================================
    // edge register clock
    // reg_clock is sampled by clock: each of its levels must last at least
    // one clock cycle, or the edge is missed
    logic reg_rise;

    assign reg_rise = reg_clock & ~state_ff.reg_clk_prev;

    // =====================================================
    // next state
    always_comb begin
        nxt_state = state_ff;
        unique case (mode)
            MODE_RESET: begin
                // drivers float after reset
                nxt_state.drv.data = {NUM_DRV{pcs_pkg::PCS_RST_DRV_DATA}};
                nxt_state.drv.oe_b = {NUM_DRV{pcs_pkg::PCS_RST_DRV_OE_B}};
                // selector
                nxt_state.sel = pcs_pkg::PCS_RST_SEL;
                // register clock history
                nxt_state.reg_clk_prev = pcs_pkg::PCS_RST_CLK_PREV;
            end
            MODE_RUN: begin
                // drivers
                nxt_state.drv.data = drv_data_calc;
                nxt_state.drv.oe_b = drv_oe_b_calc;
                // selector
                nxt_state.sel = sel_calc;
                // register clock history
                nxt_state.reg_clk_prev = reg_clock;
            end
            MODE_FROZEN: begin
                // every flop keeps its value
                nxt_state = state_ff;
            end
        endcase
    end

    // =====================================================
    // state register
    always_ff @(posedge clock) begin
        state_ff <= nxt_state;
    end

    // =====================================================
    // outputs
    assign drv_out = state_ff.drv.data;
    assign drv_oe_b = state_ff.drv.oe_b;
    assign sel_out = state_ff.sel;

    // =====================================================
    // level latch
    // transparent while lat_enable is high, at the resolution of clock
    pcs_store u_latch (
        // clock and reset
        .clock(clock),
        .rst_b(rst_b),
        .clk_en(clk_en),
        // cell controls
        .data(lat_data),
        .load(lat_enable),
        .clear(lat_clear),
        .set(lat_set),
        // values for clear and set together
        .clash_true_value(lat_clash_true_value),
        .clash_inverted_value(lat_clash_inverted_value),
        // outputs
        .true_output(lat_true_output),
        .inverted_output(lat_inverted_output)
    );

    // =====================================================
    // edge register
    // clear and set act without waiting for an edge of reg_clock
    pcs_store u_edge (
        // clock and reset
        .clock(clock),
        .rst_b(rst_b),
        .clk_en(clk_en),
        // cell controls
        .data(reg_data),
        .load(reg_rise),
        .clear(reg_clear),
        .set(reg_set),
        // values for clear and set together
        .clash_true_value(reg_clash_true_value),
        .clash_inverted_value(reg_clash_inverted_value),
        // outputs
        .true_output(reg_true_output),
        .inverted_output(reg_inverted_output)
    );

    // =====================================================
    // limitations
    // every cell here is built from flops clocked by clock: a pulse on
    // lat_enable, lat_clear, lat_set, reg_clear or reg_set shorter than one
    // clock period may be lost, and all of them act at the next clock edge
    // rather than at once
endmodule

// >>> tb/pcs_properties.sv
// checker for the drivers, selector, latch and register of the cell set
`timescale 1ns/1ps
module pcs_properties (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [3:0] drv_in,
    input wire logic [3:0] drv_enable,
    input wire logic [3:0] drv_out,
    input wire logic [3:0] drv_oe_b,
    input wire logic [1:0] sel_data,
    input wire logic sel_out,
    input wire logic lat_enable,
    input wire logic lat_clear,
    input wire logic lat_set,
    input wire logic lat_clash_true_value,
    input wire logic lat_clash_inverted_value,
    input wire logic lat_true_output,
    input wire logic lat_inverted_output,
    input wire logic reg_data,
    input wire logic reg_clock,
    input wire logic reg_clear,
    input wire logic reg_set,
    input wire logic reg_true_output,
    input wire logic reg_inverted_output
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // a rising edge of reg_clock seen over two enabled cycles, no clear or set
    sequence s_reg_rise;
        (clk_en && !reg_clock) ##1 (clk_en && reg_clock && !reg_clear && !reg_set);
    endsequence
    sequence s_lat_idle;
        clk_en && !lat_clear && !lat_set && !lat_enable;
    endsequence
    property p_lat_clash;
        clk_en && lat_clear && lat_set |=> lat_true_output == $past(lat_clash_true_value)
            && lat_inverted_output == $past(lat_clash_inverted_value);
    endproperty
    a_lat_clash: assert property (p_lat_clash) else $error("latch clash values wrong");
    property p_lat_clear; clk_en && lat_clear && !lat_set |=> !lat_true_output && lat_inverted_output; endproperty
    a_lat_clear: assert property (p_lat_clear) else $error("latch clear wrong");
    property p_lat_hold; s_lat_idle |=> $stable(lat_true_output) && $stable(lat_inverted_output); endproperty
    a_lat_hold: assert property (p_lat_hold) else $error("latch hold wrong");
    property p_reg_load;
        s_reg_rise |=> reg_true_output == $past(reg_data) && reg_inverted_output == !$past(reg_data);
    endproperty
    a_reg_load: assert property (p_reg_load) else $error("register load wrong");
    property p_reg_set; clk_en && reg_set && !reg_clear |=> reg_true_output && !reg_inverted_output; endproperty
    a_reg_set: assert property (p_reg_set) else $error("register set wrong");
    property p_oe; clk_en |=> drv_oe_b == ($past(drv_enable) ^ ~pcs_pkg::PCS_LOW_MASK); endproperty
    a_oe: assert property (p_oe) else $error("driver enable wrong");
    property p_dat; clk_en |=> drv_out == ($past(drv_in) ^ pcs_pkg::PCS_INV_MASK); endproperty
    a_dat: assert property (p_dat) else $error("driver data wrong");
    property p_sel; clk_en && sel_data[0] == sel_data[1] |=> sel_out == $past(sel_data[0]); endproperty
    a_sel: assert property (p_sel) else $error("selector wrong");
endmodule

// >>> tb/pcs_top_tb_top.sv
// testbench for the cell set
`timescale 1ns/1ps
module pcs_top_tb_top;
    logic clock = 0, rst_b = 0, clk_en = 1, sel_select = 0, sel_out;
    logic [3:0] drv_in = 0, drv_enable = 0, drv_out, drv_oe_b;
    logic [1:0] sel_data = 0;
    logic lat_data = 0, lat_enable = 0, lat_clear = 0, lat_set = 0, lat_clash_true_value = 0;
    logic lat_clash_inverted_value = 0, lat_true_output, lat_inverted_output;
    logic reg_data = 0, reg_clock = 0, reg_clear = 0, reg_set = 0, reg_clash_true_value = 0;
    logic reg_clash_inverted_value = 0, reg_true_output, reg_inverted_output;
    logic [11:0] rows [5] = '{12'ha55, 12'h5a6, 12'hf0b, 12'h0fd, 12'h3c2};
    int fail_count = 0, n_tests = 0, cyc = 0;
    pcs_top uut(.*);
    initial forever #2 clock = ~clock;
    task chk(string nm, logic [3:0] s, logic [3:0] e);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, s);
        end
    endtask
    task end_of_test;
        if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clock) if (++cyc > 200) begin fail_count++; end_of_test; end
    initial begin
        repeat (16) @(negedge clock);
        rst_b = 1;
        foreach (rows[i]) begin
            {drv_in, drv_enable, sel_data, sel_select} = rows[i][11:1];
            @(negedge clock);
            chk("drv_oe_b", drv_oe_b, drv_enable ^ ~pcs_pkg::PCS_LOW_MASK);
            chk("drv_out", drv_out, drv_in ^ pcs_pkg::PCS_INV_MASK);
            chk("sel_out", {3'h0, sel_out}, {3'h0, rows[i][0]});
        end
        // latch: clash first, then clear, set and transparent data, then hold
        lat_clear = 1'h1;
        lat_set = 1'h1;
        lat_enable = 1'h1;
        lat_clash_true_value = 1'h1;
        lat_clash_inverted_value = 1'h1;
        @(negedge clock);
        chk("lat clash", {2'h0, lat_true_output, lat_inverted_output}, 4'h3);
        lat_set = 1'h0;
        @(negedge clock);
        chk("lat clear", {2'h0, lat_true_output, lat_inverted_output}, 4'h1);
        lat_clear = 1'h0;
        lat_set = 1'h1;
        @(negedge clock);
        chk("lat set", {2'h0, lat_true_output, lat_inverted_output}, 4'h2);
        lat_set = 1'h0;
        @(negedge clock);
        chk("lat data low", {2'h0, lat_true_output, lat_inverted_output}, 4'h1);
        lat_data = 1'h1;
        @(negedge clock);
        chk("lat data high", {2'h0, lat_true_output, lat_inverted_output}, 4'h2);
        lat_enable = 1'h0;
        lat_data = 1'h0;
        @(negedge clock);
        chk("lat hold", {2'h0, lat_true_output, lat_inverted_output}, 4'h2);
        // register: no edge holds, a rising edge loads, clear and set override
        reg_data = 1'h1;
        @(negedge clock);
        chk("reg idle", {2'h0, reg_true_output, reg_inverted_output}, 4'h1);
        reg_clock = 1'h1;
        @(negedge clock);
        chk("reg load", {2'h0, reg_true_output, reg_inverted_output}, 4'h2);
        reg_data = 1'h0;
        @(negedge clock);
        chk("reg no edge", {2'h0, reg_true_output, reg_inverted_output}, 4'h2);
        reg_clear = 1'h1;
        @(negedge clock);
        chk("reg clear", {2'h0, reg_true_output, reg_inverted_output}, 4'h1);
        reg_set = 1'h1;
        @(negedge clock);
        chk("reg clash", {2'h0, reg_true_output, reg_inverted_output}, 4'h0);
        reg_clear = 1'h0;
        @(negedge clock);
        chk("reg set", {2'h0, reg_true_output, reg_inverted_output}, 4'h2);
        reg_set = 1'h0;
        reg_clock = 1'h0;
        // clock enable low freezes the latch outputs and drv_out
        clk_en = 1'h0;
        lat_enable = 1'h1;
        drv_in = ~drv_in;
        @(negedge clock);
        chk("frozen lat", {2'h0, lat_true_output, lat_inverted_output}, 4'h2);
        chk("frozen drv_out", drv_out, ~drv_in ^ pcs_pkg::PCS_INV_MASK);
        clk_en = 1'h1;
        // mid-run reset loads the reset values
        rst_b = 1'h0;
        @(negedge clock);
        chk("reset drv_oe_b", drv_oe_b, {4{pcs_pkg::PCS_RST_DRV_OE_B}});
        chk("reset lat", {2'h0, lat_true_output, lat_inverted_output},
            {2'h0, pcs_pkg::PCS_RST_TRUE, pcs_pkg::PCS_RST_INV});
        chk("reset reg", {2'h0, reg_true_output, reg_inverted_output},
            {2'h0, pcs_pkg::PCS_RST_TRUE, pcs_pkg::PCS_RST_INV});
        rst_b = 1'h1;
        @(negedge clock);
        chk("lat after reset", {2'h0, lat_true_output, lat_inverted_output}, 4'h1);
        end_of_test;
    end
endmodule
bind pcs_top pcs_properties chk_i(.*);
